// [design/dcc_top.sv]
/*
 * Dual comparator control: configuration, input and output routing selects,
 * result synchronisation, change flag and interrupt request, AXI4-Lite slave.
 * Assumes analog comparators outside deliver raw results on CMPx_RAW and
 * obey the input selects; REF_CLK runs at 250 MHz.
 */
// Function
// - Raw result high when plus above minus
// - Bits 5 and 4 invert results
// - Results read-only bits 7:6, reset zero
// - Bits 2:0 select one of eight modes
// - Mode 010 switch picks pins 3,2 or 0,1
// - Mode 010 plus inputs use reference
// - Modes 110, 001 route raw results out
// - Direction bits still gate pin drivers
// - Analog pins read zero in port data
// - Result differing from record sets flag
// - Flag bit 6; write zero clears, one sets
// - Request only with all three enables
// - Config read or write refreshes record
// - Persisting mismatch keeps setting flag
// - Change during config read still sets flag
// - Reset returns mode 000, comparators off
// - Comparators run in sleep, config kept
`include "dcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CMP1_RAW,
    input wire logic CMP2_RAW,
    input wire logic [4:0] PORT_A_IN,
    output logic [4:0] PORT_A_OUT,
    output logic [4:0] PORT_A_OE_N,
    output logic [3:0] ANALOG_PIN_EN,
    output logic CMP1_MINUS_SEL,
    output logic CMP1_MINUS_PIN3,
    output logic CMP2_MINUS_PIN2,
    output logic CMPS_PLUS_VREF,
    output logic CMP1_POWER,
    output logic CMP2_POWER,
    output logic COMPARE_CHANGE_IRQ
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [5:0] config_reg, config_next;
    logic [4:0] dir_reg, dir_next, port_latch_reg, port_latch_next;
    logic flag_reg, flag_next, cmp_en_reg, cmp_en_next;
    logic periph_en_reg, periph_en_next, glob_en_reg, glob_en_next;
    logic [1:0] record_reg, record_next;
    logic [1:0] sync1_reg, sync2_reg;
    logic [4:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_val_reg, pin_val_next;
    dcc_pkg::dcc_bus_state_t wst_reg, wst_next, rst_reg, rst_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic [4:0] pin_out_next, pin_oe_n_next;
    logic [3:0] analog_next;
    logic sel_next, pin3_next, pin2_next, vref_next, pw1_next, pw2_next;
    logic irq_reg, irq_next;

    // Decodes which of pins 0..4 are analog inputs in a mode.
    function automatic logic [4:0] analog_mask(input logic [2:0] m);
        unique case (dcc_pkg::dcc_mode_t'(m))
            dcc_pkg::DCC_MODE_RESET: analog_mask = 5'h0f;
            dcc_pkg::DCC_MODE_ONE_SWITCHED: analog_mask = 5'h0b;
            dcc_pkg::DCC_MODE_FOUR_MUXED: analog_mask = 5'h0f;
            dcc_pkg::DCC_MODE_TWO_COMMON: analog_mask = 5'h07;
            dcc_pkg::DCC_MODE_TWO_INDEP: analog_mask = 5'h0f;
            dcc_pkg::DCC_MODE_ONE_INDEP: analog_mask = 5'h03;
            dcc_pkg::DCC_MODE_TWO_COMMON_OUT: analog_mask = 5'h07;
            dcc_pkg::DCC_MODE_OFF: analog_mask = 5'h00;
        endcase
    endfunction

    // Synchronised, inverted results as software sees them.
    logic [1:0] result;
    logic [2:0] mode;
    logic [1:0] raw_inv;
    assign mode = config_reg[2:0];
    assign result = sync2_reg ^ config_reg[5:4];
    // Unsynchronised results for the pins, inverted like the status bits.
    assign raw_inv = {CMP2_RAW, CMP1_RAW} ^ config_reg[5:4];

    // ------------------------------------------------------------------
    // Bus slave and block logic
    // ------------------------------------------------------------------
    logic w_fire, r_fire, cfg_touch;
    logic [7:0] araddr;
    assign araddr = S_AXI_ARADDR[7:0];
    assign w_fire = aw_got_reg && w_got_reg && wst_reg == dcc_pkg::DCC_BUS_IDLE;
    assign r_fire = S_AXI_ARVALID && rst_reg == dcc_pkg::DCC_BUS_IDLE;

    // Computes next values of registers, bus and outputs.
    always_comb begin
        logic [7:0] wb;
        logic [4:0] mask;
        wb = wdata_reg[7:0];
        mask = analog_mask(mode);
        config_next = config_reg;
        dir_next = dir_reg;
        port_latch_next = port_latch_reg;
        flag_next = flag_reg;
        cmp_en_next = cmp_en_reg;
        periph_en_next = periph_en_reg;
        glob_en_next = glob_en_reg;
        record_next = record_reg;
        wst_next = wst_reg;
        rst_next = rst_reg;
        rdata_next = rdata_reg;
        bresp_next = bresp_reg;
        rresp_next = rresp_reg;
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        cfg_touch = 1'b0;
        // Address and data are latched independently, in either order.
        if (S_AXI_AWVALID && !aw_got_reg) begin
            aw_got_next = 1'b1;
            awaddr_next = S_AXI_AWADDR[7:0];
        end
        if (S_AXI_WVALID && !w_got_reg) begin
            w_got_next = 1'b1;
            wdata_next = S_AXI_WDATA;
            wstrb_next = S_AXI_WSTRB;
        end
        // A write with both halves present executes and answers.
        if (w_fire) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            wst_next = dcc_pkg::DCC_BUS_RESP;
            bresp_next = 2'b00;
            if (wstrb_reg[0]) begin
                unique case (awaddr_reg)
                    `DCC_OFF_CONFIG: begin
                        config_next = wb[5:0];
                        cfg_touch = 1'b1;
                    end
                    `DCC_OFF_FLAGS: flag_next = wb[`DCC_BIT_FLAG];
                    `DCC_OFF_ENABLES: begin
                        cmp_en_next = wb[`DCC_BIT_CMP_ENABLE];
                        periph_en_next = wb[`DCC_BIT_PERIPH_ENABLE];
                        glob_en_next = wb[`DCC_BIT_GLOBAL_ENABLE];
                    end
                    `DCC_OFF_PORT: port_latch_next = wb[4:0];
                    `DCC_OFF_DIR: dir_next = wb[4:0];
                    default: bresp_next = 2'b10;
                endcase
            end else if (!(awaddr_reg inside {`DCC_OFF_CONFIG, `DCC_OFF_FLAGS,
                    `DCC_OFF_ENABLES, `DCC_OFF_PORT, `DCC_OFF_DIR})) begin
                bresp_next = 2'b10;
            end else if (awaddr_reg == `DCC_OFF_CONFIG) begin
                cfg_touch = 1'b1;
            end
        end
        if (wst_reg == dcc_pkg::DCC_BUS_RESP && S_AXI_BREADY) begin
            wst_next = dcc_pkg::DCC_BUS_IDLE;
        end
        // Reads; port data shows zero on analog pins.
        if (r_fire) begin
            rst_next = dcc_pkg::DCC_BUS_RESP;
            rresp_next = 2'b00;
            unique case (araddr)
                `DCC_OFF_CONFIG: begin
                    rdata_next = {24'h0, result, config_reg};
                    cfg_touch = 1'b1;
                end
                `DCC_OFF_FLAGS: rdata_next = {24'h0, 1'b0, flag_reg, 6'h0};
                `DCC_OFF_ENABLES: rdata_next = {24'h0, 1'b0, cmp_en_reg,
                    4'h0, periph_en_reg, glob_en_reg};
                `DCC_OFF_PORT: rdata_next = {27'h0, pin_val_reg & ~mask};
                `DCC_OFF_DIR: rdata_next = {27'h0, dir_reg};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = 2'b10;
                end
            endcase
        end
        if (rst_reg == dcc_pkg::DCC_BUS_RESP && S_AXI_RREADY) begin
            rst_next = dcc_pkg::DCC_BUS_IDLE;
        end
        // Any config access records the current results; the new record
        // is compared next cycle and the old one this cycle, so no change at that edge is missed.
        if (cfg_touch) begin
            record_next = result;
        end
        // Mismatch sets flag and wins over a software clear.
        if (record_reg != result) begin
            flag_next = 1'b1;
        end
        irq_next = flag_reg && cmp_en_reg && periph_en_reg && glob_en_reg;
        // Input and output routing from the mode and switch.
        sel_next = config_reg[`DCC_BIT_INPUT_SWITCH];
        pin3_next = (mode == 3'h1 || mode == 3'h2) && sel_next;
        pin2_next = mode == 3'h2 && sel_next;
        vref_next = mode == 3'h2;
        pw1_next = !(mode == 3'h0 || mode == 3'h7);
        pw2_next = pw1_next && mode != 3'h1 && mode != 3'h5;
        analog_next = mask[3:0];
        pin_out_next = port_latch_reg;
        if (mode == 3'h6 || mode == 3'h1) begin
            pin_out_next[4:3] = raw_inv;
        end
        pin_oe_n_next = dir_reg | mask;
        pin_val_next = pin_s3_reg;
        if (pin_s2_reg == pin_s3_reg) begin
            pin_val_next = pin_s3_reg;
        end else begin
            pin_val_next = pin_val_reg;
        end
    end

    // ------------------------------------------------------------------
    // Flip-flops; CLK_EN freezes everything, state kept across sleep
    // ------------------------------------------------------------------
    // Registers the state and outputs.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            config_reg <= `DCC_RST_CONFIG;
            dir_reg <= `DCC_RST_DIR;
            port_latch_reg <= `DCC_RST_PORT;
            {flag_reg, cmp_en_reg, periph_en_reg, glob_en_reg} <= 4'h0;
            record_reg <= 2'h0;
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            pin_s1_reg <= 5'h0;
            pin_s2_reg <= 5'h0;
            pin_s3_reg <= 5'h0;
            pin_val_reg <= 5'h0;
            wst_reg <= dcc_pkg::DCC_BUS_IDLE;
            rst_reg <= dcc_pkg::DCC_BUS_IDLE;
            rdata_reg <= 32'h0;
            bresp_reg <= 2'h0;
            rresp_reg <= 2'h0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            irq_reg <= 1'b0;
            PORT_A_OUT <= 5'h0;
            PORT_A_OE_N <= 5'h1f;
            ANALOG_PIN_EN <= 4'hf;
            {CMP1_MINUS_SEL, CMP1_MINUS_PIN3, CMP2_MINUS_PIN2} <= 3'h0;
            {CMPS_PLUS_VREF, CMP1_POWER, CMP2_POWER} <= 3'h0;
        end else if (CLK_EN) begin
            config_reg <= config_next;
            dir_reg <= dir_next;
            port_latch_reg <= port_latch_next;
            flag_reg <= flag_next;
            cmp_en_reg <= cmp_en_next;
            periph_en_reg <= periph_en_next;
            glob_en_reg <= glob_en_next;
            record_reg <= record_next;
            sync1_reg <= {CMP2_RAW, CMP1_RAW};
            sync2_reg <= sync1_reg;
            pin_s1_reg <= PORT_A_IN;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_val_reg <= pin_val_next;
            wst_reg <= wst_next;
            rst_reg <= rst_next;
            rdata_reg <= rdata_next;
            bresp_reg <= bresp_next;
            rresp_reg <= rresp_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            irq_reg <= irq_next;
            PORT_A_OUT <= pin_out_next;
            PORT_A_OE_N <= pin_oe_n_next;
            ANALOG_PIN_EN <= analog_next;
            CMP1_MINUS_SEL <= sel_next;
            CMP1_MINUS_PIN3 <= pin3_next;
            CMP2_MINUS_PIN2 <= pin2_next;
            CMPS_PLUS_VREF <= vref_next;
            CMP1_POWER <= pw1_next;
            CMP2_POWER <= pw2_next;
        end
    end

    // Bus handshake outputs, all from flip-flops.
    assign S_AXI_AWREADY = aw_got_reg;
    assign S_AXI_WREADY = w_got_reg;
    assign S_AXI_BVALID = wst_reg == dcc_pkg::DCC_BUS_RESP;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = rst_reg == dcc_pkg::DCC_BUS_IDLE;
    assign S_AXI_RVALID = rst_reg == dcc_pkg::DCC_BUS_RESP;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign COMPARE_CHANGE_IRQ = irq_reg;
endmodule // dcc_top
`default_nettype wire

// [design/dcc_defs.svh]
/*
 * Offsets, field positions and reset values of the dual comparator
 * control block. Assumes inclusion by bare name from design files.
 */
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
`define DCC_IDX_CONFIG 6'h1f
`define DCC_OFF_CONFIG {`DCC_IDX_CONFIG, 2'b00}
`define DCC_OFF_FLAGS 8'h30
`define DCC_OFF_ENABLES 8'h34
`define DCC_OFF_PORT 8'h38
`define DCC_OFF_DIR 8'h3c
`define DCC_BIT_CMP2_RESULT 7
`define DCC_BIT_CMP1_RESULT 6
`define DCC_BIT_CMP2_INVERT 5
`define DCC_BIT_CMP1_INVERT 4
`define DCC_BIT_INPUT_SWITCH 3
`define DCC_BIT_FLAG 6
`define DCC_BIT_CMP_ENABLE 6
`define DCC_BIT_PERIPH_ENABLE 1
`define DCC_BIT_GLOBAL_ENABLE 0
`define DCC_RST_CONFIG 6'h00
`define DCC_RST_DIR 5'h1f
`define DCC_RST_PORT 5'h00
`endif

// [design/dcc_pkg.sv]
/*
 * Types of the dual comparator control block.
 * Assumes no other package.
 */
package dcc_pkg;
    typedef enum logic [2:0] {
        DCC_MODE_RESET = 3'h0,
        DCC_MODE_ONE_SWITCHED = 3'h1,
        DCC_MODE_FOUR_MUXED = 3'h2,
        DCC_MODE_TWO_COMMON = 3'h3,
        DCC_MODE_TWO_INDEP = 3'h4,
        DCC_MODE_ONE_INDEP = 3'h5,
        DCC_MODE_TWO_COMMON_OUT = 3'h6,
        DCC_MODE_OFF = 3'h7
    } dcc_mode_t;
    typedef enum {
        DCC_BUS_IDLE,
        DCC_BUS_RESP
    } dcc_bus_state_t;
endpackage

// [testbench/dcc_checker.sv]
/* Concurrent checks on the ports of dcc_top.
   Assumes one clock, REF_CLK, and the asynchronous active-low RSTN. */
`timescale 1ns/1ps
`default_nettype none
module dcc_checker (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_RVALID,
    input wire logic [4:0] PORT_A_OE_N,
    input wire logic [3:0] ANALOG_PIN_EN,
    input wire logic CMP1_MINUS_PIN3,
    input wire logic CMP2_MINUS_PIN2,
    input wire logic CMPS_PLUS_VREF,
    input wire logic CMP1_POWER,
    input wire logic CMP2_POWER,
    input wire logic COMPARE_CHANGE_IRQ
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    property p_bresp_holds; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
    endproperty
    a_bresp_holds: assert property (p_bresp_holds)
        else $error("Write response dropped early.");
    property p_wr_answer; S_AXI_AWVALID && S_AXI_WVALID |-> ##[1:8] S_AXI_BVALID;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("Write got no response.");
    property p_rd_answer; $rose(S_AXI_ARVALID) |-> ##[1:8] S_AXI_RVALID;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("Read got no data.");
    property p_reset_mode; $rose(RSTN) |-> ANALOG_PIN_EN == 4'hf &&
        PORT_A_OE_N == 5'h1f && !CMP1_POWER && !CMP2_POWER; endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("Block left reset outside mode zero.");
    property p_vref_mask; CMPS_PLUS_VREF |-> ANALOG_PIN_EN == 4'hf; endproperty
    a_vref_mask: assert property (p_vref_mask)
        else $error("Reference applied outside the muxed mode.");
    property p_pin2_vref; CMP2_MINUS_PIN2 |-> CMPS_PLUS_VREF; endproperty
    a_pin2_vref: assert property (p_pin2_vref)
        else $error("Pin two selected outside the muxed mode.");
    property p_pin3_analog; CMP1_MINUS_PIN3 |-> ANALOG_PIN_EN[3]; endproperty
    a_pin3_analog: assert property (p_pin3_analog)
        else $error("Pin three selected while digital.");
    property p_oe_analog;
        (PORT_A_OE_N[3:0] & ANALOG_PIN_EN) == ANALOG_PIN_EN; endproperty
    a_oe_analog: assert property (p_oe_analog)
        else $error("Analog pin driven.");
    cover property (CMPS_PLUS_VREF && CMP1_MINUS_PIN3);
    cover property (COMPARE_CHANGE_IRQ);
    cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule // dcc_checker
bind dcc_top dcc_checker i_dcc_checker (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_RVALID(S_AXI_RVALID),
    .PORT_A_OE_N(PORT_A_OE_N), .ANALOG_PIN_EN(ANALOG_PIN_EN),
    .CMP1_MINUS_PIN3(CMP1_MINUS_PIN3), .CMP2_MINUS_PIN2(CMP2_MINUS_PIN2),
    .CMPS_PLUS_VREF(CMPS_PLUS_VREF), .CMP1_POWER(CMP1_POWER),
    .CMP2_POWER(CMP2_POWER), .COMPARE_CHANGE_IRQ(COMPARE_CHANGE_IRQ));
`default_nettype wire

// [testbench/dcc_analog_model.sv]
/* Analog pins and comparators in front of dcc_top.
   Assumes the bench sets pin and reference levels. */
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model (
    input wire logic [7:0] v_pin [4],
    input wire logic [7:0] v_ref,
    input wire logic minus1_pin3,
    input wire logic minus2_pin2,
    input wire logic plus_vref,
    input wire logic pwr1,
    input wire logic pwr2,
    output logic raw1,
    output logic raw2
);
    // A powered-down comparator gives a steady low.
    logic [7:0] plus_lvl;
    assign plus_lvl = plus_vref ? v_ref : v_pin[2];
    assign raw1 = pwr1 &&
        (plus_lvl > (minus1_pin3 ? v_pin[3] : v_pin[0]));
    assign raw2 = pwr2 &&
        (plus_lvl > (minus2_pin2 ? v_pin[2] : v_pin[1]));
endmodule // dcc_analog_model
`default_nettype wire

// [testbench/dcc_top_tb.sv]
/* Self-checking bench of dcc_top: mode table, then flag, inversion,
   output routing, refusal and reset cases. Assumes dcc_analog_model. */
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb;
    // ------------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------------
    logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic bry = 1'b0, rry = 1'b0, awr, wrd, bv, arr, rv, raw1, raw2, sel;
    logic p3, p2, pv, pw1, pw2, irq, cke = 1'b1;
    logic [31:0] adr = 32'h0, wd = 32'h0, rd, rq;
    logic [1:0] br, rrs, rr;
    logic [4:0] pin_in = 5'h00, pout, oen;
    logic [3:0] ana;
    logic [7:0] v_pin [4] = '{8'h40, 8'hc0, 8'h80, 8'h40};
    logic [7:0] v_ref = 8'h80;
    int n_mismatch = 0, checks_done = 0;
    // Switch and power levels, config byte, then vref, pin3, pin2 selects
    // and analog mask.
    logic [19:0] rows [10] = '{20'h0000f, 20'h2010b, 20'h6094b, 20'h3028f,
        20'h70aef, 20'h30307, 20'h3040f, 20'h20503, 20'h30607, 20'h00700};
    always #2 clk = ~clk;
    dcc_top i_dcc_top (.REF_CLK(clk), .RSTN(rstn), .CLK_EN(cke),
        .S_AXI_AWADDR(adr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_ARADDR(adr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rrs),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .CMP1_RAW(raw1),
        .CMP2_RAW(raw2), .PORT_A_IN(pin_in), .PORT_A_OUT(pout),
        .PORT_A_OE_N(oen), .ANALOG_PIN_EN(ana), .CMP1_MINUS_SEL(sel),
        .CMP1_MINUS_PIN3(p3), .CMP2_MINUS_PIN2(p2), .CMPS_PLUS_VREF(pv),
        .CMP1_POWER(pw1), .CMP2_POWER(pw2), .COMPARE_CHANGE_IRQ(irq));
    dcc_analog_model i_dcc_analog_model (.v_pin(v_pin), .v_ref(v_ref),
        .minus1_pin3(p3), .minus2_pin2(p2), .plus_vref(pv), .pwr1(pw1),
        .pwr2(pw2), .raw1(raw1), .raw2(raw2));
    // Compares one byte and reports a mismatch at once.
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One bus write or read; each channel is released when it is taken.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awv <= w;
        wv <= w;
        bry <= w;
        arv <= !w;
        rry <= !w;
        adr <= {24'h0, a};
        wd <= {24'h0, d};
        while (n < 30) begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (arr) arv <= 1'b0;
            if (w ? bv : rv) break;
        end
        rq = rd;
        rr = w ? br : rrs;
        if (n == 30) chk(8'h00, 8'h01);
        {awv, wv, bry, arv, rry} <= 5'h00;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    // Mode table first, then the hand-written cases.
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            acc(1'b1, 8'h7c, rows[i][15:8]);
            repeat (3) @(posedge clk);
            chk({pv, p3, p2, 1'b0, ana}, rows[i][7:0]);
            chk({5'h0, sel, pw1, pw2}, {5'h0, rows[i][18:16]});
            acc(1'b0, 8'h7c, 8'h00);
            chk({2'h0, rq[5:0]}, {2'h0, rows[i][13:8]});
        end
        acc(1'b1, 8'h7c, 8'h02);
        acc(1'b1, 8'h34, 8'h43);
        repeat (4) @(posedge clk);
        acc(1'b0, 8'h7c, 8'h00);
        chk(rq[7:0], 8'h42);
        acc(1'b1, 8'h30, 8'h00);
        repeat (4) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        v_pin[0] <= 8'hc0;
        repeat (8) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        acc(1'b1, 8'h30, 8'h00);
        repeat (4) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        acc(1'b1, 8'h7c, 8'h02);
        acc(1'b1, 8'h30, 8'h00);
        repeat (4) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        acc(1'b1, 8'h30, 8'h40);
        repeat (4) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        acc(1'b1, 8'h34, 8'h42);
        repeat (4) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        acc(1'b1, 8'h7c, 8'hd2);
        repeat (4) @(posedge clk);
        acc(1'b0, 8'h7c, 8'h00);
        chk(rq[7:0], 8'h52);
        acc(1'b1, 8'h7c, 8'h06);
        acc(1'b1, 8'h3c, 8'h07);
        v_pin[0] <= 8'h40;
        repeat (4) @(posedge clk);
        chk({4'h0, oen[4:3], pout[4:3]}, {6'h0, raw2, raw1});
        acc(1'b1, 8'h3c, 8'h1f);
        repeat (4) @(posedge clk);
        chk({6'h0, oen[4:3]}, 8'h03);
        // Pins 2..0 still show the port data latch.
        acc(1'b1, 8'h38, 8'h05);
        repeat (2) @(posedge clk);
        chk({5'h0, pout[2:0]}, 8'h05);
        // A frozen clock enable holds the routed result and the config.
        cke <= 1'b0;
        v_pin[0] <= 8'hc0;
        repeat (4) @(posedge clk);
        chk({7'h0, pout[3]}, 8'h01);
        cke <= 1'b1;
        v_pin[0] <= 8'h40;
        repeat (4) @(posedge clk);
        acc(1'b0, 8'h7c, 8'h00);
        chk(rq[7:0], 8'h46);
        acc(1'b1, 8'h7c, 8'h00);
        pin_in <= 5'h1f;
        repeat (6) @(posedge clk);
        acc(1'b0, 8'h38, 8'h00);
        chk(rq[7:0], 8'h10);
        acc(1'b1, 8'h40, 8'h55);
        chk({6'h0, rr}, 8'h02);
        acc(1'b0, 8'h44, 8'h00);
        chk({6'h0, rr}, 8'h02);
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({3'h0, oen}, 8'h1f);
        chk({4'h0, ana}, 8'h0f);
        acc(1'b0, 8'h7c, 8'h00);
        chk(rq[7:0], 8'h00);
        close_out();
    end
endmodule // dcc_top_tb
`default_nettype wire
